// ### hw/nvsp_pkg.sv
// constants, types and state layout for the nonvolatile access front end
// Functional notes
// - keep requesting the cpu clock in sleep while a write or erase runs
// - a debugger halt of the cpu freezes normal operation of this block
// - flash write and erase always act on one whole aligned page
// - loader section runs from zero to the loader fuse times 256 bytes
// - program section spans loader end to program end, the rest is data
// - program fuse zero with loader nonzero: program section reaches flash end
// - both fuses zero: the whole flash is the loader section
// - code in the loader section may write program and data sections
// - code in the program section may write the data section only
// - code in the data section writes neither flash nor eeprom
// - the program lock bit blocks program section updates until reset, the loader lock blocks no updates
// - no cpu write ever reaches the loader section
// - loader lock blocks data reads and fetches from the loader section
// - eeprom page erase and write touch only bytes marked in the page buffer, CMD_EEER erases every byte
// - the 32 byte user page survives a chip erase
// - the programming interface may write the user page on a locked part
// - an array read during a busy operation stalls the bus until done
// - eeprom programming never stops instruction fetch from flash
// - buffer loads and with old content, buffer returns to all ones
package nvsp_pkg;
	// ******************************
	// sizes and address map
	// ******************************
	localparam int FUSE_W = 8;
	localparam int AW = 16;
	localparam int DW = 32;
	localparam int BYTE_W = 8;
	localparam int BPW = 4;
	localparam int WORD_LSB = 2;
	localparam int PAGE_BYTES = 32;
	localparam int PAGE_LSB = 5;
	localparam int WIDX_W = 3;
	localparam int BLOCK_LSB = 8;
	localparam int REG_OFF_W = 8;
	localparam int CMD_W = 3;
	localparam logic [AW:0] FLASH_END = 17'h01000;
	localparam logic [AW-1:0] FLASH_BASE = 16'h8000;
	localparam logic [AW-1:0] FLASH_TOP = 16'h8fff;
	localparam logic [AW-1:0] REG_BASE = 16'h1000;
	localparam logic [AW-1:0] REG_TOP = 16'h10ff;
	localparam logic [AW-1:0] USER_BASE = 16'h1300;
	localparam logic [AW-1:0] USER_TOP = 16'h131f;
	localparam logic [AW-1:0] EE_BASE = 16'h1400;
	localparam logic [AW-1:0] EE_TOP = 16'h147f;
	// ******************************
	// registers, fields, commands
	// ******************************
	localparam logic [REG_OFF_W-1:0] REG_CMD = 8'h00;
	localparam logic [REG_OFF_W-1:0] REG_LOCK = 8'h04;
	localparam logic [REG_OFF_W-1:0] REG_ADDR = 8'h08;
	localparam logic [REG_OFF_W-1:0] REG_STATUS = 8'h0c;
	localparam int LOCK_PROG_BIT = 0;
	localparam int LOCK_LOADER_BIT = 1;
	localparam int ST_FBUSY = 0;
	localparam int ST_EBUSY = 1;
	localparam int ST_ERR = 2;
	localparam int ST_BOOT_LSB = 8;
	localparam int ST_APP_LSB = 16;
	localparam logic [CMD_W-1:0] CMD_WRITE = 3'h1;
	localparam logic [CMD_W-1:0] CMD_ERASE = 3'h2;
	localparam logic [CMD_W-1:0] CMD_ERWR = 3'h3;
	localparam logic [CMD_W-1:0] CMD_PBCLR = 3'h4;
	localparam logic [CMD_W-1:0] CMD_CHIP = 3'h5;
	localparam logic [CMD_W-1:0] CMD_EEER = 3'h6;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	// ******************************
	// types
	// ******************************
	typedef enum logic [2:0] {BUS_IDLE, BUS_DATA, BUS_ARD, BUS_ARW, BUS_RESP} nvsp_bus_e;
	typedef enum logic [1:0] {SECT_BOOT, SECT_PROG, SECT_DATA} nvsp_sect_e;
	typedef enum logic [2:0] {RGN_NONE, RGN_REG, RGN_FLASH, RGN_EE, RGN_USER} nvsp_rgn_e;
	typedef struct packed {
		nvsp_bus_e bus;
		logic [AW-1:0] baddr;
		logic bwr;
		nvsp_rgn_e brgn;
		logic [DW-1:0] rdata;
		logic ready;
		logic resp;
		logic rd_req;
		logic [AW-1:0] raddr;
		logic [FUSE_W-1:0] fb;
		logic [FUSE_W-1:0] fa;
		logic cap;
		logic plock;
		logic llock;
		logic [AW-1:0] tgt;
		nvsp_rgn_e trgn;
		logic [PAGE_BYTES-1:0][BYTE_W-1:0] pbuf;
		logic [PAGE_BYTES-1:0] mark;
		logic fbusy;
		logic ebusy;
		logic err;
		logic start;
		logic [CMD_W-1:0] cmd;
		logic ofl;
		logic ous;
		logic [PAGE_BYTES-1:0] omask;
		logic slp;
		logic creq;
		logic fdeny;
	} nvsp_state_s;
endpackage

// ### hw/nvsp_access.sv
// section protection and access front end of the nonvolatile controller
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
module nvsp_access
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// ahb-lite register and memory port
	input wire logic hsel,
	input wire logic [nvsp_pkg::DW-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [nvsp_pkg::DW-1:0] hwdata,
	input wire logic hready,
	output logic [nvsp_pkg::DW-1:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// fuses and system state
	input wire logic [nvsp_pkg::FUSE_W-1:0] boot_section_end_fuse,
	input wire logic [nvsp_pkg::FUSE_W-1:0] app_code_section_end_fuse,
	input wire logic sleep,
	input wire logic dbg_halt,
	input wire logic ext_mode,
	input wire logic dev_locked,
	output logic clk_req,
	// cpu fetch side
	input wire logic [nvsp_pkg::AW-1:0] exec_addr,
	input wire logic [nvsp_pkg::AW-1:0] fetch_addr,
	output logic fetch_deny,
	output logic fetch_stall,
	// array read port
	output logic arr_rd_req,
	output logic [nvsp_pkg::AW-1:0] arr_addr,
	input wire logic [nvsp_pkg::DW-1:0] arr_rd_data,
	// array operation port
	output logic op_start,
	output logic [nvsp_pkg::CMD_W-1:0] op_cmd,
	output logic op_flash,
	output logic op_user,
	output logic [nvsp_pkg::AW-1:0] op_page,
	output logic [nvsp_pkg::PAGE_BYTES-1:0] op_mask,
	output logic [nvsp_pkg::PAGE_BYTES*nvsp_pkg::BYTE_W-1:0] op_data,
	input wire logic op_done
);
	import nvsp_pkg::*;

	// ******************************
	// state and section bounds
	// ******************************
	nvsp_state_s s;
	nvsp_state_s n;
	logic [AW:0] boot_end;
	logic [AW:0] app_raw;
	logic [AW:0] app_end;
	logic busy;
	logic accept;
	logic pb_load;
	logic pb_clr;
	logic tgt_ok;
	logic ee_ok;
	logic boot_read;
	nvsp_sect_e exec_sect;
	nvsp_sect_e fetch_sect;
	nvsp_sect_e tgt_sect;
	logic [PAGE_BYTES-1:0][BYTE_W-1:0] pb_new;
	logic [PAGE_BYTES-1:0] pb_hit;

	// section ends in bytes, whole 256 byte blocks
	assign app_raw = {1'b0, s.fa, {BLOCK_LSB{1'b0}}};
	assign boot_end = (s.fb == '0 && s.fa == '0) ? FLASH_END :
		{1'b0, s.fb, {BLOCK_LSB{1'b0}}};
	// a nonzero program fuse below the loader fuse collapses the program section
	assign app_end = (s.fa == '0) ? FLASH_END :
		((app_raw < boot_end) ? boot_end : app_raw);

	function automatic nvsp_sect_e sect_of(input logic [AW-1:0] off);
		if ({1'b0, off} < boot_end)
			return SECT_BOOT;
		if ({1'b0, off} < app_end)
			return SECT_PROG;
		return SECT_DATA;
	endfunction

	function automatic nvsp_rgn_e rgn_of(input logic [AW-1:0] a);
		if (a >= FLASH_BASE && a <= FLASH_TOP)
			return RGN_FLASH;
		if (a >= REG_BASE && a <= REG_TOP)
			return RGN_REG;
		if (a >= EE_BASE && a <= EE_TOP)
			return RGN_EE;
		if (a >= USER_BASE && a <= USER_TOP)
			return RGN_USER;
		return RGN_NONE;
	endfunction

	// write permission by origin of the executing code
	function automatic logic may_write(input nvsp_rgn_e r, input nvsp_sect_e t,
		input nvsp_sect_e e);
		if (ext_mode)
			return !dev_locked || r == RGN_USER;
		if (e == SECT_DATA)
			return 1'b0;
		case (r)
			RGN_FLASH:
			begin
				if (t == SECT_PROG)
					return e == SECT_BOOT && !s.plock;
				return t == SECT_DATA;
			end
			RGN_EE, RGN_USER: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// ******************************
	// decode helpers
	// ******************************
	assign busy = s.fbusy || s.ebusy;
	assign accept = hsel && hready && htrans == HTRANS_NONSEQ;
	assign exec_sect = sect_of(exec_addr);
	assign fetch_sect = sect_of(fetch_addr);
	assign tgt_sect = sect_of(s.tgt - FLASH_BASE);
	assign tgt_ok = may_write(s.trgn, tgt_sect, exec_sect);
	assign ee_ok = may_write(RGN_EE, SECT_DATA, exec_sect);
	// loads into the buffer wait while an operation still owns it
	assign pb_load = s.bus == BUS_DATA && s.bwr && !busy && !dbg_halt &&
		(s.brgn == RGN_FLASH || s.brgn == RGN_EE || s.brgn == RGN_USER);
	assign boot_read = !ext_mode && s.brgn == RGN_FLASH && s.llock &&
		sect_of(s.baddr - FLASH_BASE) == SECT_BOOT;

	// per byte buffer merge, new data anded into old content
	genvar g;
	for (g = 0; g < PAGE_BYTES; g++)
	begin : g_pb
		assign pb_hit[g] = pb_load &&
			s.baddr[PAGE_LSB-1:WORD_LSB] == WIDX_W'(g >> WORD_LSB);
		assign pb_new[g] = pb_hit[g] ?
			(s.pbuf[g] & hwdata[(g % BPW) * BYTE_W +: BYTE_W]) : s.pbuf[g];
	end

	// ******************************
	// next state
	// ******************************
	always_comb
	begin
		n = s;
		pb_clr = 1'b0;
		n.start = 1'b0;
		n.rd_req = 1'b0;
		n.slp = sleep;
		n.creq = busy || !sleep;
		n.fdeny = s.llock && fetch_sect == SECT_BOOT;
		// fuses caught once, on the first edge after reset
		if (!s.cap)
		begin
			n.fb = boot_section_end_fuse;
			n.fa = app_code_section_end_fuse;
			n.cap = 1'b1;
		end
		// a load also points the page target at its page
		if (pb_load)
		begin
			n.pbuf = pb_new;
			n.mark = s.mark | pb_hit;
			n.tgt = {s.baddr[AW-1:PAGE_LSB], {PAGE_LSB{1'b0}}};
			n.trgn = s.brgn;
		end
		// engine freezes under debug halt, yet an address shown ready is still taken
		if (!dbg_halt || (accept && (s.bus == BUS_IDLE || s.bus == BUS_RESP)))
		begin
			case (s.bus)
				BUS_IDLE, BUS_RESP:
				begin
					n.bus = BUS_IDLE;
					if (accept)
					begin
						n.baddr = haddr[AW-1:0];
						n.bwr = hwrite;
						n.brgn = rgn_of(haddr[AW-1:0]);
						n.ready = 1'b0;
						n.bus = BUS_DATA;
					end
				end
				BUS_DATA:
				begin
					if (s.bwr && s.brgn == RGN_REG)
					begin
						n.ready = 1'b1;
						n.bus = BUS_RESP;
						case (s.baddr[REG_OFF_W-1:0])
							REG_CMD:
							begin
								n.cmd = hwdata[CMD_W-1:0];
								if (busy)
									n.err = 1'b1;
								else
								begin
									case (hwdata[CMD_W-1:0])
										CMD_PBCLR: pb_clr = 1'b1;
										CMD_WRITE, CMD_ERASE, CMD_ERWR:
										begin
											if (tgt_ok)
											begin
												n.start = 1'b1;
												n.ofl = s.trgn == RGN_FLASH;
												n.ous = s.trgn == RGN_USER;
												// flash takes the page whole, eeprom only marks
												n.omask = (s.trgn == RGN_FLASH) ? '1 : s.mark;
												n.fbusy = s.trgn == RGN_FLASH;
												n.ebusy = s.trgn != RGN_FLASH;
											end
											else
												n.err = 1'b1;
										end
										CMD_CHIP:
										begin
											if (ext_mode)
											begin
												n.start = 1'b1;
												n.ofl = 1'b1;
												n.ous = 1'b0;
												n.omask = '1;
												n.fbusy = 1'b1;
											end
											else
												n.err = 1'b1;
										end
										CMD_EEER:
										begin
											if (ee_ok)
											begin
												n.start = 1'b1;
												n.ofl = 1'b0;
												n.ous = 1'b0;
												n.omask = '1;
												n.ebusy = 1'b1;
											end
											else
												n.err = 1'b1;
										end
										default: n.err = s.err;
									endcase
								end
							end
							REG_LOCK:
							begin
								// set only, nothing but reset clears them
								n.plock = s.plock || hwdata[LOCK_PROG_BIT];
								n.llock = s.llock || hwdata[LOCK_LOADER_BIT];
							end
							REG_ADDR:
							begin
								n.tgt = {hwdata[AW-1:PAGE_LSB], {PAGE_LSB{1'b0}}};
								n.trgn = rgn_of(hwdata[AW-1:0]);
							end
							REG_STATUS:
							begin
								if (hwdata[ST_ERR])
									n.err = 1'b0;
							end
							default: n.err = s.err;
						endcase
					end
					else if (s.bwr)
					begin
						// unmapped writes vanish, buffer loads wait for idle
						if (!busy || s.brgn == RGN_NONE)
						begin
							n.ready = 1'b1;
							n.bus = BUS_RESP;
						end
					end
					else if (s.brgn == RGN_REG)
					begin
						n.rdata = '0;
						case (s.baddr[REG_OFF_W-1:0])
							REG_CMD: n.rdata[CMD_W-1:0] = s.cmd;
							REG_LOCK:
							begin
								n.rdata[LOCK_PROG_BIT] = s.plock;
								n.rdata[LOCK_LOADER_BIT] = s.llock;
							end
							REG_ADDR: n.rdata[AW-1:0] = s.tgt;
							REG_STATUS:
							begin
								n.rdata[ST_FBUSY] = s.fbusy;
								n.rdata[ST_EBUSY] = s.ebusy;
								n.rdata[ST_ERR] = s.err;
								n.rdata[ST_BOOT_LSB +: FUSE_W] = s.fb;
								n.rdata[ST_APP_LSB +: FUSE_W] = s.fa;
							end
							default: n.rdata = '0;
						endcase
						n.ready = 1'b1;
						n.bus = BUS_RESP;
					end
					else if (s.brgn == RGN_NONE || boot_read)
					begin
						n.rdata = '0;
						n.ready = 1'b1;
						n.bus = BUS_RESP;
					end
					else if (!busy)
					begin
						n.rd_req = 1'b1;
						n.raddr = s.baddr;
						n.bus = BUS_ARD;
					end
				end
				BUS_ARD: n.bus = BUS_ARW;
				BUS_ARW:
				begin
					n.rdata = arr_rd_data;
					n.ready = 1'b1;
					n.bus = BUS_RESP;
				end
				default: n.bus = BUS_IDLE;
			endcase
		end
		// end of an operation frees the buffer back to all ones
		if (op_done)
		begin
			n.fbusy = 1'b0;
			n.ebusy = 1'b0;
			pb_clr = 1'b1;
		end
		if ((s.slp && !sleep) || pb_clr)
		begin
			n.pbuf = '1;
			n.mark = '0;
		end
	end

	// state register, buffer comes up erased
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			s <= '0;
			s.pbuf <= '1;
			s.ready <= 1'b1;
		end
		else
			s <= n;
	end

	// ******************************
	// outputs
	// ******************************
	assign hrdata = s.rdata;
	assign hreadyout = s.ready;
	assign hresp = s.resp;
	assign clk_req = s.creq;
	assign fetch_deny = s.fdeny;
	assign fetch_stall = s.fbusy;
	assign arr_rd_req = s.rd_req;
	assign arr_addr = s.raddr;
	assign op_start = s.start;
	assign op_cmd = s.cmd;
	assign op_flash = s.ofl;
	assign op_user = s.ous;
	assign op_page = s.tgt;
	assign op_mask = s.omask;
	assign op_data = s.pbuf;

	// ******************************
	// checks
	// ******************************
	a_loader_never_written: assert property (@(posedge clk_sys) disable iff (rst)
		s.start && s.ofl && s.cmd != CMD_CHIP |-> tgt_sect != SECT_BOOT)
		else $error("flash operation aimed at loader section");
	a_read_stalls: assert property (@(posedge clk_sys) disable iff (rst)
		s.bus == BUS_DATA && !s.bwr && busy && !dbg_halt &&
		s.brgn != RGN_REG && s.brgn != RGN_NONE && !boot_read |=> s.bus == BUS_DATA && !s.ready)
		else $error("array read not stalled while busy");
	a_locks_sticky: assert property (@(posedge clk_sys) disable iff (rst)
		!$fell(s.plock) && !$fell(s.llock))
		else $error("lock bit cleared without reset");
	a_fuse_held: assert property (@(posedge clk_sys) disable iff (rst)
		s.cap |=> $stable(s.fb) && $stable(s.fa) && s.cap)
		else $error("fuse copy changed after capture");
	a_fetch_denied: assert property (@(posedge clk_sys) disable iff (rst)
		s.llock && fetch_sect == SECT_BOOT |=> fetch_deny)
		else $error("locked loader fetch not denied");
	a_clock_kept: assert property (@(posedge clk_sys) disable iff (rst)
		busy |=> clk_req)
		else $error("clock request dropped while busy");
	a_data_exec_blocked: assert property (@(posedge clk_sys) disable iff (rst)
		s.start |-> $past(ext_mode) || $past(exec_sect) != SECT_DATA)
		else $error("operation launched from data section code");
	a_flash_whole_page: assert property (@(posedge clk_sys) disable iff (rst)
		s.start && s.ofl |-> s.omask == '1 && s.tgt[PAGE_LSB-1:0] == '0)
		else $error("partial flash page operation");
	a_buffer_erased: assert property (@(posedge clk_sys) disable iff (rst)
		op_done |=> s.pbuf == '1 && s.mark == '0)
		else $error("page buffer not erased after operation");
	a_debug_freeze: assert property (@(posedge clk_sys) disable iff (rst)
		dbg_halt |=> !s.start && ($stable(s.bus) || $past(accept)))
		else $error("bus engine moved during debug halt");
endmodule

// ### testbench/nvsp_array_model.sv
// array side model: timed read data and timed operation completion
module nvsp_array_model
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// read port
	input wire logic arr_rd_req,
	input wire logic [nvsp_pkg::AW-1:0] arr_addr,
	output logic [nvsp_pkg::DW-1:0] arr_rd_data,
	// operation port
	input wire logic op_start,
	input wire logic [7:0] op_delay,
	output logic op_done
);
	timeunit 1ns;
	timeprecision 1ps;
	import nvsp_pkg::*;
	int left;
	// data valid only one cycle after a request, it churns otherwise
	always @(posedge clk_sys)
	begin
		op_done <= 1'b0;
		arr_rd_data <= rst ? '0 : arr_rd_req ? {~arr_addr, arr_addr} : ~arr_rd_data;
		if (rst)
			left = 0;
		else if (op_start)
			left = op_delay;
		else if (left > 0)
		begin
			left--;
			op_done <= (left == 0);
		end
	end
endmodule

// ### testbench/nvsp_access_tb.sv
// self-checking bench for the nonvolatile access front end
module nvsp_access_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import nvsp_pkg::*;
	logic clk_sys, rst, hsel, hwrite, hreadyout, hresp, sleep, dbg_halt, ext_mode, dev_locked;
	logic clk_req, fetch_deny, fetch_stall, arr_rd_req, op_start, op_flash, op_user, op_done;
	logic [DW-1:0] haddr, hwdata, hrdata, arr_rd_data;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [FUSE_W-1:0] boot_section_end_fuse, app_code_section_end_fuse;
	logic [AW-1:0] exec_addr, fetch_addr, arr_addr, op_page, lpage;
	logic [CMD_W-1:0] op_cmd, lcmd;
	logic [PAGE_BYTES-1:0] op_mask, lmask, marks;
	logic [255:0] op_data, ldata, pbuf;
	logic [7:0] op_delay;
	logic lflash, luser, plock;
	int err_count, checked, fb, fa;
	int cyc = 0;
	int ops = 0;
	int done_cyc = 0;
	nvsp_access dut (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .boot_section_end_fuse,
		.app_code_section_end_fuse, .sleep, .dbg_halt, .ext_mode, .dev_locked, .clk_req,
		.exec_addr, .fetch_addr, .fetch_deny, .fetch_stall, .arr_rd_req, .arr_addr,
		.arr_rd_data, .op_start, .op_cmd, .op_flash, .op_user, .op_page, .op_mask,
		.op_data, .op_done);
	nvsp_array_model far (.clk_sys, .rst, .arr_rd_req, .arr_addr, .arr_rd_data,
		.op_start, .op_delay, .op_done);
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// capture each launch so tasks can compare after the edge
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (op_done === 1'b1)
			done_cyc <= cyc;
		if (op_start === 1'b1)
		begin
			ops <= ops + 1;
			{lcmd, lflash, luser, lpage, lmask, ldata} <=
				{op_cmd, op_flash, op_user, op_page, op_mask, op_data};
		end
	end
	// ******************************
	// bus tasks and reference model
	// ******************************
	task automatic chk(input logic [255:0] seen, input logic [255:0] exp, input string s);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t %s seen %h exp %h", $time, s, seen, exp);
		end
	endtask
	task automatic wait_rdy();
		int n;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 400);
		if (n >= 400)
			chk(0, 1, "bus hang");
	endtask
	// address phase held until ready, then data phase held until ready
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		r = hrdata;
	endtask
	function automatic logic [31:0] ra(input logic [7:0] o);
		return {16'h0, REG_BASE | {8'h0, o}};
	endfunction
	// 0 loader, 1 program, 2 data
	function automatic int sect(input int off);
		if (fb == 0 && fa == 0)
			return 0;
		if (off < fb * 256)
			return 0;
		if (fa == 0)
			return 1;
		if (fa <= fb || off >= fa * 256)
			return 2;
		return 1;
	endfunction
	function automatic logic allowed(input int e, input int ta, input logic fl);
		int es;
		es = sect(e);
		if (!fl)
			return es != 2;
		case (sect(ta - 32'h8000))
			0: return 1'b0;
			1: return es == 0 && !plock;
			default: return es != 2;
		endcase
	endfunction
	task automatic wait_idle();
		logic [31:0] r;
		int n;
		n = 0;
		do
		begin
			bus(0, ra(REG_STATUS), 0, r);
			n++;
		end
		while (r[1:0] !== 2'h0 && n < 100);
		chk(256'(r[1:0]), 0, "idle");
	endtask
	// load one word, issue a command, compare launch against the model
	task automatic cmd_try(input int e, input logic [31:0] ta, input logic [2:0] c,
		input logic ok, input logic isf, input logic isu);
		logic [31:0] r;
		logic [31:0] d;
		int n0;
		int w;
		exec_addr <= e[15:0];
		d = $urandom;
		w = (ta >> 2) & 7;
		bus(1, ta, d, r);
		pbuf[w*32 +: 32] = pbuf[w*32 +: 32] & d;
		marks[w*4 +: 4] = 4'hf;
		n0 = ops;
		bus(1, ra(REG_CMD), {29'h0, c}, r);
		@(posedge clk_sys);
		chk(256'(ops - n0), 256'(ok), "launch");
		if (ok)
		begin
			chk({lcmd, lflash, luser, lpage}, {c, isf, isu, ta[15:5], 5'h0}, "op");
			chk(lmask, isf ? {PAGE_BYTES{1'b1}} : marks, "mask");
			chk(ldata, pbuf, "data");
			wait_idle();
		end
		else
		begin
			bus(0, ra(REG_STATUS), 0, r);
			chk(256'(r[ST_ERR]), 1, "err");
			bus(1, ra(REG_STATUS), 32'h4, r);
			exec_addr <= '0;
			bus(1, ra(REG_CMD), {29'h0, CMD_PBCLR}, r);
		end
		pbuf = '1;
		marks = '0;
	endtask
	task automatic rand_cmds(input int k);
		int g;
		int e;
		int o;
		logic [31:0] ta;
		for (int i = 0; i < k; i++)
		begin
			g = $urandom_range(0, 4);
			e = $urandom_range(0, 4095);
			o = $urandom_range(0, 4095) & 32'hffc;
			ta = g < 3 ? 32'h8000 + o : g == 3 ? 32'h1400 + (o & 32'h7c) : 32'h1300 + (o & 32'h1c);
			cmd_try(e, ta, 3'($urandom_range(1, 3)), allowed(e, ta, g < 3), g < 3, g == 4);
		end
	endtask
	task automatic do_reset(input int b, input int a);
		logic [31:0] r;
		fb = b;
		fa = a;
		plock = 1'b0;
		boot_section_end_fuse <= b[7:0];
		app_code_section_end_fuse <= a[7:0];
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		boot_section_end_fuse <= ~b[7:0];
		app_code_section_end_fuse <= ~a[7:0];
		pbuf = '1;
		marks = '0;
		bus(0, ra(REG_STATUS), 0, r);
		chk(r[23:8], {a[7:0], b[7:0]}, "fuses");
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ******************************
	// test sequence
	// ******************************
	initial
	begin
		logic [31:0] r;
		int t0;
		{rst, hsel, hwrite, sleep, dbg_halt, ext_mode, dev_locked} = 7'b1100000;
		{haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
		{exec_addr, fetch_addr, op_delay} = {32'h0, 8'h3};
		{err_count, checked} = 0;
		void'($urandom(87));
		do_reset(4, 8);
		chk({hreadyout, hresp}, 2'b10, "reset");
		chk(op_data, {256{1'b1}}, "reset");
		cmd_try(0, 32'h8404, CMD_WRITE, 1, 1, 0);
		cmd_try(32'h400, 32'h8504, CMD_ERASE, 0, 1, 0);
		cmd_try(32'h400, 32'h8810, CMD_ERWR, 1, 1, 0);
		cmd_try(32'h900, 32'h1408, CMD_WRITE, 0, 0, 0);
		cmd_try(0, 32'h8100, CMD_WRITE, 0, 1, 0);
		rand_cmds(30);
		$display("test sections done");
		bus(1, ra(REG_LOCK), 32'h1, r);
		plock = 1'b1;
		cmd_try(0, 32'h8400, CMD_WRITE, 0, 1, 0);
		bus(1, ra(REG_LOCK), 32'h0, r);
		cmd_try(0, 32'h8420, CMD_ERWR, 0, 1, 0);
		bus(1, ra(REG_LOCK), 32'h2, r);
		bus(0, 32'h8010, 0, r);
		chk(r, 0, "locked read");
		bus(0, 32'h8410, 0, r);
		chk(r, {16'h7bef, 16'h8410}, "read");
		fetch_addr <= 16'h0010;
		repeat (2) @(posedge clk_sys);
		chk(256'(fetch_deny), 1, "deny");
		fetch_addr <= 16'h0500;
		repeat (2) @(posedge clk_sys);
		chk(256'(fetch_deny), 0, "deny");
		$display("test locks done");
		op_delay <= 8'd40;
		bus(1, 32'h8800, 32'h1, r);
		bus(1, ra(REG_CMD), {29'h0, CMD_WRITE}, r);
		t0 = cyc;
		@(posedge clk_sys);
		chk(256'(fetch_stall), 1, "stall");
		bus(0, 32'h8810, 0, r);
		chk(r, {16'h77ef, 16'h8810}, "busy read");
		chk(256'(done_cyc >= t0 + 38), 1, "read waited");
		bus(1, 32'h1408, 32'h5, r);
		bus(1, ra(REG_CMD), {29'h0, CMD_ERWR}, r);
		@(posedge clk_sys);
		chk(256'(fetch_stall), 0, "no stall");
		bus(0, ra(REG_STATUS), 0, r);
		chk(256'(r[ST_EBUSY]), 1, "ee busy");
		sleep <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk(256'(clk_req), 1, "clk req");
		repeat (45) @(posedge clk_sys);
		chk(256'(clk_req), 0, "clk free");
		sleep <= 1'b0;
		op_delay <= 8'd3;
		@(posedge clk_sys);
		$display("test busy done");
		dbg_halt <= 1'b1;
		t0 = cyc;
		fork
			bus(0, ra(REG_STATUS), 0, r);
			begin
				repeat (12) @(posedge clk_sys);
				dbg_halt <= 1'b0;
			end
		join
		chk(256'(cyc - t0 >= 12), 1, "halt");
		bus(0, 32'h2000, 0, r);
		chk(r, 0, "unmapped");
		ext_mode <= 1'b1;
		dev_locked <= 1'b1;
		cmd_try(32'h900, 32'h1304, CMD_WRITE, 1, 0, 1);
		cmd_try(32'h900, 32'h8404, CMD_WRITE, 0, 1, 0);
		dev_locked <= 1'b0;
		for (int i = 0; i < 2; i++)
		begin
			t0 = ops;
			bus(1, ra(REG_CMD), {29'h0, i == 0 ? CMD_CHIP : CMD_EEER}, r);
			@(posedge clk_sys);
			chk({8'(ops - t0), lcmd, luser},
				{8'd1, i == 0 ? CMD_CHIP : CMD_EEER, 1'b0}, "ext");
			wait_idle();
		end
		ext_mode <= 1'b0;
		$display("test external done");
		do_reset(4, 0);
		rand_cmds(20);
		do_reset(0, 0);
		rand_cmds(20);
		do_reset(6, 3);
		rand_cmds(20);
		$display("test fuses done");
		give_verdict();
	end
	// whole run needs about 2000 cycles, this cuts a hang at 100000
	initial
	begin
		#400000;
		err_count++;
		give_verdict();
	end
endmodule
